// file: verilog/evc_map.svh
// Offsets, field positions, reset values and mode codes for the catch.
`ifndef EVC_MAP_SVH
`define EVC_MAP_SVH
`define EVC_CATCH_RESET 32'h0000_0000
`define EVC_CATCH_WMASK 32'hDE00_DCDF
`define EVC_FAULT_RESET 32'h0000_0000
`define EVC_HIGH_BASE 32'hFFFF_0000
`define EVC_OFS_RESET 32'h0000_0000
`define EVC_OFS_UNDEF 32'h0000_0004
`define EVC_OFS_CALL 32'h0000_0008
`define EVC_OFS_PABT 32'h0000_000C
`define EVC_OFS_DABT 32'h0000_0010
`define EVC_OFS_IRQ 32'h0000_0018
`define EVC_OFS_FAST 32'h0000_001C
`define EVC_ADJ_WIDE 32'h0000_0008
`define EVC_ADJ_NARROW 32'h0000_0004
`define EVC_MODE_MONITOR 5'h16
`define EVC_DMODE_EXCEPTION 2'h2
`define EVC_DMODE_HALT 2'h1
`define EVC_BIT_NS_FAST 31
`define EVC_BIT_NS_IRQ 30
`define EVC_BIT_NS_DABT 28
`define EVC_BIT_NS_PABT 27
`define EVC_BIT_NS_CALL 26
`define EVC_BIT_NS_UNDEF 25
`define EVC_BIT_MB_FAST 15
`define EVC_BIT_MB_IRQ 14
`define EVC_BIT_MB_DABT 12
`define EVC_BIT_MB_PABT 11
`define EVC_BIT_MB_CALL 10
`define EVC_BIT_S_FAST 7
`define EVC_BIT_S_IRQ 6
`define EVC_BIT_S_DABT 4
`define EVC_BIT_S_PABT 3
`define EVC_BIT_S_CALL 2
`define EVC_BIT_S_UNDEF 1
`define EVC_BIT_RESET 0
`endif

// file: verilog/evc_pkg.sv
// Types shared by the vector catch files.
package evc_pkg;
  typedef enum logic [1:0] {
    EVC_ISET_WIDE,
    EVC_ISET_NARROW,
    EVC_ISET_BYTE
  } evc_iset_t;

  // Security context and vector bases supplied by the core.
  typedef struct packed {
    logic nonsecureStateFlag;
    logic [4:0] procMode;
    logic highVectorsSelect;
    logic vectoredIrqEnable;
    logic [31:0] secureVectorBase;
    logic [31:0] nonsecureVectorBase;
    logic [31:0] monitorVectorBase;
    logic [31:0] lastSecureIrqAddr;
    logic [31:0] lastNonsecureIrqAddr;
  } evc_ctx_t;

  // Instruction fetch that has been committed for execution.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } evc_fetch_t;

  // Watchpoint hit report.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    evc_iset_t iset;
  } evc_wpt_t;

  // Coprocessor register access.
  typedef struct packed {
    logic writeCatch;
    logic writeFault;
    logic [31:0] data;
  } evc_cpw_t;
endpackage

// file: verilog/evc_match.sv
// Combinational match of one fetch address against the catch enables of the current security world.
`timescale 1ns/1ps
`include "evc_map.svh"
module evc_match (
  // Inputs.
  input wire logic [31:0] catchEn,
  input wire evc_pkg::evc_ctx_t ctx,
  input wire logic [31:0] fetchAddr,
  // Result.
  output logic hit
);
  import evc_pkg::*;

  function automatic logic [31:0] vecAddr(input logic [31:0] base,
      input logic hi, input logic [31:0] ofs);
    vecAddr = (hi ? `EVC_HIGH_BASE : base) + ofs;
  endfunction

  logic secureSide;
  logic [31:0] sIrq;
  logic [31:0] nsIrq;
  logic [31:0] sb;
  logic [31:0] nb;
  logic [31:0] mb;
  logic hv;

  always_comb begin
    hv = ctx.highVectorsSelect;
    sb = ctx.secureVectorBase;
    nb = ctx.nonsecureVectorBase;
    mb = ctx.monitorVectorBase;
    // R4 R5 secure world choice
    secureSide = !ctx.nonsecureStateFlag ||
                 (ctx.procMode == `EVC_MODE_MONITOR);
    // R13 secure irq address
    sIrq = ctx.vectoredIrqEnable ? ctx.lastSecureIrqAddr :
           vecAddr(sb, hv, `EVC_OFS_IRQ);
    // R16 nonsecure irq address
    nsIrq = ctx.vectoredIrqEnable ? ctx.lastNonsecureIrqAddr :
            vecAddr(nb, hv, `EVC_OFS_IRQ);
    hit = 1'b0;
    if (secureSide) begin
      // R11 reset vector
      if (catchEn[`EVC_BIT_RESET] &&
          fetchAddr == (hv ? `EVC_HIGH_BASE : `EVC_OFS_RESET))
        hit = 1'b1;
      // R10 R12 secure base group
      if (catchEn[`EVC_BIT_S_UNDEF] &&
          fetchAddr == vecAddr(sb, hv, `EVC_OFS_UNDEF))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_S_CALL] &&
          fetchAddr == vecAddr(sb, hv, `EVC_OFS_CALL))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_S_PABT] &&
          fetchAddr == vecAddr(sb, hv, `EVC_OFS_PABT))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_S_DABT] &&
          fetchAddr == vecAddr(sb, hv, `EVC_OFS_DABT))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_S_IRQ] && fetchAddr == sIrq)
        hit = 1'b1;
      if (catchEn[`EVC_BIT_S_FAST] &&
          fetchAddr == vecAddr(sb, hv, `EVC_OFS_FAST))
        hit = 1'b1;
      // R9 R14 monitor base group
      if (catchEn[`EVC_BIT_MB_CALL] &&
          fetchAddr == vecAddr(mb, 1'b0, `EVC_OFS_CALL))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_MB_PABT] &&
          fetchAddr == vecAddr(mb, 1'b0, `EVC_OFS_PABT))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_MB_DABT] &&
          fetchAddr == vecAddr(mb, 1'b0, `EVC_OFS_DABT))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_MB_IRQ] &&
          fetchAddr == vecAddr(mb, 1'b0, `EVC_OFS_IRQ))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_MB_FAST] &&
          fetchAddr == vecAddr(mb, 1'b0, `EVC_OFS_FAST))
        hit = 1'b1;
    end else begin
      // R8 R15 nonsecure base group
      if (catchEn[`EVC_BIT_NS_UNDEF] &&
          fetchAddr == vecAddr(nb, hv, `EVC_OFS_UNDEF))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_NS_CALL] &&
          fetchAddr == vecAddr(nb, hv, `EVC_OFS_CALL))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_NS_PABT] &&
          fetchAddr == vecAddr(nb, hv, `EVC_OFS_PABT))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_NS_DABT] &&
          fetchAddr == vecAddr(nb, hv, `EVC_OFS_DABT))
        hit = 1'b1;
      if (catchEn[`EVC_BIT_NS_IRQ] && fetchAddr == nsIrq)
        hit = 1'b1;
      if (catchEn[`EVC_BIT_NS_FAST] &&
          fetchAddr == vecAddr(nb, hv, `EVC_OFS_FAST))
        hit = 1'b1;
    end
  end
endmodule

// file: verilog/evc_vector_catch.sv
// Vector catch enables, watchpoint fault address holder and catch events.
`timescale 1ns/1ps
`include "evc_map.svh"
// Notes on behaviour
// R1 - Writing the fault address holder loads the written word.
// R2 - Enabled caught vector raises exception or halt per two-bit mode field.
// R3 - Any committed fetch from a caught address triggers, not only exceptions.
// R4 - Low sixteen enables only trigger on Secure-world fetches.
// R5 - Top seven enables only trigger on Non-secure-world fetches.
// R6 - A catch enable write takes effect by the next instruction barrier.
// R7 - Reserved enable bits read as zero and ignore writes.
// R8 - Non-secure enables at bits 31,30,28..25; reset to zero.
// R9 - Monitor-base enables at bits 15,14,12..10; reset to zero.
// R10 - Secure-base enables at bits 7,6,4..1.
// R11 - Bit 0 catches address zero, or high base with high vectors.
// R12 - Secure group: secure base plus offset, or high base plus offset.
// R13 - Vectored secure irq catch uses last secure handler address.
// R14 - Monitor group: monitor base plus offset, unaffected by other settings.
// R15 - Non-secure group when flag set and not monitor mode.
// R16 - Vectored non-secure irq catch uses last non-secure handler address.
// R17 - Watchpoint hit records address plus eight, four, or zero by state.
// R18 - Security, mode, vector settings and bases come in from the core.
module evc_vector_catch (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Coprocessor writes and barrier.
  input wire evc_pkg::evc_cpw_t cpWrite,
  input wire logic instructionMemoryBarrier,
  // Core context, fetch and watchpoint.
  // R18 core context inputs
  input wire evc_pkg::evc_ctx_t ctx,
  input wire evc_pkg::evc_fetch_t fetch,
  input wire evc_pkg::evc_wpt_t wpt,
  input wire logic [1:0] debugModeSel,
  // Register views.
  output logic [31:0] vectorCatchEnables,
  output logic [31:0] watchpointFaultPc,
  // Catch events.
  output logic catchException,
  output logic catchHalt
);
  import evc_pkg::*;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [31:0] catchWritten_reg;
  logic [31:0] catchWritten_next;
  logic [31:0] catchActive_reg;
  logic [31:0] catchActive_next;
  logic [31:0] faultPc_reg;
  logic [31:0] faultPc_next;
  logic excp_reg;
  logic excp_next;
  logic halt_reg;
  logic halt_next;
  logic hit;

  evc_match uMatch (
    .catchEn(catchActive_reg),
    .ctx(ctx),
    .fetchAddr(fetch.addr),
    .hit(hit)
  );

  always_comb begin
    catchWritten_next = catchWritten_reg;
    catchActive_next = catchActive_reg;
    faultPc_next = faultPc_reg;
    // R7 reserved bits dropped
    if (cpWrite.writeCatch)
      catchWritten_next = cpWrite.data & `EVC_CATCH_WMASK;
    // R6 barrier makes new enables active
    if (instructionMemoryBarrier)
      catchActive_next = catchWritten_next;
    // R17 fault address by state
    if (wpt.valid) begin
      case (wpt.iset)
        EVC_ISET_WIDE: faultPc_next = wpt.addr + `EVC_ADJ_WIDE;
        EVC_ISET_NARROW: faultPc_next = wpt.addr + `EVC_ADJ_NARROW;
        default: faultPc_next = wpt.addr;
      endcase
    end
    // R1 software write wins over hit
    if (cpWrite.writeFault)
      faultPc_next = cpWrite.data;
    // R2 R3 event by debug mode
    excp_next = fetch.valid && hit &&
                debugModeSel == `EVC_DMODE_EXCEPTION;
    halt_next = fetch.valid && hit && debugModeSel == `EVC_DMODE_HALT;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // R8 R9 enables reset clear
      catchWritten_reg <= `EVC_CATCH_RESET;
      catchActive_reg <= `EVC_CATCH_RESET;
      faultPc_reg <= `EVC_FAULT_RESET;
      excp_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      catchWritten_reg <= catchWritten_next;
      catchActive_reg <= catchActive_next;
      faultPc_reg <= faultPc_next;
      excp_reg <= excp_next;
      halt_reg <= halt_next;
    end
  end

  assign vectorCatchEnables = catchWritten_reg;
  assign watchpointFaultPc = faultPc_reg;
  assign catchException = excp_reg;
  assign catchHalt = halt_reg;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_reserved_zero: assert property ( // R7
    (vectorCatchEnables & ~`EVC_CATCH_WMASK) == 32'h0000_0000)
    else $error("reserved catch bit set");
  chk_fault_write: assert property ( // R1
    cpWrite.writeFault |=> watchpointFaultPc == $past(cpWrite.data))
    else $error("fault write not loaded");
  chk_fault_wide: assert property ( // R17
    wpt.valid && !cpWrite.writeFault && wpt.iset == EVC_ISET_WIDE
    |=> watchpointFaultPc == $past(wpt.addr) + `EVC_ADJ_WIDE)
    else $error("wide fault address wrong");
  chk_barrier_apply: assert property ( // R6
    cpWrite.writeCatch && instructionMemoryBarrier
    |=> catchActive_reg == ($past(cpWrite.data) & `EVC_CATCH_WMASK))
    else $error("barrier did not apply enables");
  chk_no_early: assert property ( // R6
    !instructionMemoryBarrier |=> $stable(catchActive_reg))
    else $error("enables changed without barrier");
  chk_excp_cause: assert property ( // R2
    fetch.valid && hit && debugModeSel == `EVC_DMODE_EXCEPTION
    |=> catchException && !catchHalt)
    else $error("exception catch missing");
  chk_halt_cause: assert property ( // R2
    catchHalt |-> $past(fetch.valid && hit &&
    debugModeSel == `EVC_DMODE_HALT))
    else $error("halt without cause");
  chk_ns_silent: assert property ( // R4
    ctx.nonsecureStateFlag && ctx.procMode != `EVC_MODE_MONITOR &&
    (catchActive_reg[31:25] == 7'h00) |-> !hit)
    else $error("secure enable fired in nonsecure world");
  chk_s_silent: assert property ( // R5
    (!ctx.nonsecureStateFlag || ctx.procMode == `EVC_MODE_MONITOR) &&
    (catchActive_reg[15:0] == 16'h0000) |-> !hit)
    else $error("nonsecure enable fired in secure world");
  chk_reset_vec: assert property ( // R11
    catchActive_reg[0] && !ctx.nonsecureStateFlag &&
    !ctx.highVectorsSelect && fetch.addr == 32'h0000_0000 |-> hit)
    else $error("reset vector not caught");

  // ****************************************************************
  // Per-vector checks.
  // ****************************************************************
  // The caught addresses are rebuilt here from the context alone, so a
  // slip in the shared match decode cannot hide behind itself.
  logic chkSecure;
  logic chkVect;
  logic [31:0] chkSBase;
  logic [31:0] chkNBase;
  logic [31:0] chkMBase;
  logic [31:0] chkAddr;
  logic [31:0] chkEn;

  assign chkSecure = !ctx.nonsecureStateFlag ||
                     ctx.procMode == `EVC_MODE_MONITOR;
  assign chkVect = ctx.vectoredIrqEnable;
  assign chkSBase = ctx.highVectorsSelect ? `EVC_HIGH_BASE :
                    ctx.secureVectorBase;
  assign chkNBase = ctx.highVectorsSelect ? `EVC_HIGH_BASE :
                    ctx.nonsecureVectorBase;
  assign chkMBase = ctx.monitorVectorBase;
  assign chkAddr = fetch.addr;
  assign chkEn = catchActive_reg;

  // True when the fetch address sits at an offset from a vector base.
  function automatic logic atVec(input logic [31:0] addr,
      input logic [31:0] base, input logic [31:0] ofs);
    atVec = (addr == base + ofs);
  endfunction

  chk_reset_high: assert property ( // R11
    chkSecure && chkEn[`EVC_BIT_RESET] && ctx.highVectorsSelect &&
    chkAddr == `EVC_HIGH_BASE |-> hit)
    else $error("high reset vector not caught");
  chk_s_undef: assert property ( // R10 R12
    chkSecure && chkEn[`EVC_BIT_S_UNDEF] &&
    atVec(chkAddr, chkSBase, `EVC_OFS_UNDEF) |-> hit)
    else $error("secure undefined vector not caught");
  chk_s_call: assert property ( // R10 R12
    chkSecure && chkEn[`EVC_BIT_S_CALL] &&
    atVec(chkAddr, chkSBase, `EVC_OFS_CALL) |-> hit)
    else $error("secure call vector not caught");
  chk_s_pabt: assert property ( // R10 R12
    chkSecure && chkEn[`EVC_BIT_S_PABT] &&
    atVec(chkAddr, chkSBase, `EVC_OFS_PABT) |-> hit)
    else $error("secure prefetch abort vector not caught");
  chk_s_dabt: assert property ( // R10 R12
    chkSecure && chkEn[`EVC_BIT_S_DABT] &&
    atVec(chkAddr, chkSBase, `EVC_OFS_DABT) |-> hit)
    else $error("secure data abort vector not caught");
  chk_s_irq: assert property ( // R10 R12
    chkSecure && !chkVect && chkEn[`EVC_BIT_S_IRQ] &&
    atVec(chkAddr, chkSBase, `EVC_OFS_IRQ) |-> hit)
    else $error("secure irq vector not caught");
  chk_s_fast: assert property ( // R10 R12
    chkSecure && chkEn[`EVC_BIT_S_FAST] &&
    atVec(chkAddr, chkSBase, `EVC_OFS_FAST) |-> hit)
    else $error("secure fast interrupt vector not caught");
  chk_s_vect_irq: assert property ( // R13
    chkSecure && chkVect && chkEn[`EVC_BIT_S_IRQ] &&
    chkAddr == ctx.lastSecureIrqAddr |-> hit)
    else $error("secure vectored irq not caught");
  chk_mb_call: assert property ( // R9 R14
    chkSecure && chkEn[`EVC_BIT_MB_CALL] &&
    atVec(chkAddr, chkMBase, `EVC_OFS_CALL) |-> hit)
    else $error("monitor call vector not caught");
  chk_mb_pabt: assert property ( // R9 R14
    chkSecure && chkEn[`EVC_BIT_MB_PABT] &&
    atVec(chkAddr, chkMBase, `EVC_OFS_PABT) |-> hit)
    else $error("monitor prefetch abort vector not caught");
  chk_mb_dabt: assert property ( // R9 R14
    chkSecure && chkEn[`EVC_BIT_MB_DABT] &&
    atVec(chkAddr, chkMBase, `EVC_OFS_DABT) |-> hit)
    else $error("monitor data abort vector not caught");
  chk_mb_irq: assert property ( // R9 R14
    chkSecure && chkEn[`EVC_BIT_MB_IRQ] &&
    atVec(chkAddr, chkMBase, `EVC_OFS_IRQ) |-> hit)
    else $error("monitor irq vector not caught");
  chk_mb_fast: assert property ( // R9 R14
    chkSecure && chkEn[`EVC_BIT_MB_FAST] &&
    atVec(chkAddr, chkMBase, `EVC_OFS_FAST) |-> hit)
    else $error("monitor fast interrupt vector not caught");
  chk_ns_undef: assert property ( // R8 R15
    !chkSecure && chkEn[`EVC_BIT_NS_UNDEF] &&
    atVec(chkAddr, chkNBase, `EVC_OFS_UNDEF) |-> hit)
    else $error("nonsecure undefined vector not caught");
  chk_ns_call: assert property ( // R8 R15
    !chkSecure && chkEn[`EVC_BIT_NS_CALL] &&
    atVec(chkAddr, chkNBase, `EVC_OFS_CALL) |-> hit)
    else $error("nonsecure call vector not caught");
  chk_ns_pabt: assert property ( // R8 R15
    !chkSecure && chkEn[`EVC_BIT_NS_PABT] &&
    atVec(chkAddr, chkNBase, `EVC_OFS_PABT) |-> hit)
    else $error("nonsecure prefetch abort vector not caught");
  chk_ns_dabt: assert property ( // R8 R15
    !chkSecure && chkEn[`EVC_BIT_NS_DABT] &&
    atVec(chkAddr, chkNBase, `EVC_OFS_DABT) |-> hit)
    else $error("nonsecure data abort vector not caught");
  chk_ns_irq: assert property ( // R8 R15
    !chkSecure && !chkVect && chkEn[`EVC_BIT_NS_IRQ] &&
    atVec(chkAddr, chkNBase, `EVC_OFS_IRQ) |-> hit)
    else $error("nonsecure irq vector not caught");
  chk_ns_fast: assert property ( // R8 R15
    !chkSecure && chkEn[`EVC_BIT_NS_FAST] &&
    atVec(chkAddr, chkNBase, `EVC_OFS_FAST) |-> hit)
    else $error("nonsecure fast interrupt vector not caught");
  chk_ns_vect_irq: assert property ( // R16
    !chkSecure && chkVect && chkEn[`EVC_BIT_NS_IRQ] &&
    chkAddr == ctx.lastNonsecureIrqAddr |-> hit)
    else $error("nonsecure vectored irq not caught");

  // ****************************************************************
  // Register and event checks.
  // ****************************************************************
  chk_fault_narrow: assert property ( // R17
    wpt.valid && !cpWrite.writeFault && wpt.iset == EVC_ISET_NARROW
    |=> watchpointFaultPc == $past(wpt.addr) + `EVC_ADJ_NARROW)
    else $error("narrow fault address wrong");
  chk_fault_byte: assert property ( // R17
    wpt.valid && !cpWrite.writeFault && wpt.iset == EVC_ISET_BYTE
    |=> watchpointFaultPc == $past(wpt.addr))
    else $error("byte fault address wrong");
  chk_fault_hold: assert property ( // R17
    !wpt.valid && !cpWrite.writeFault |=> $stable(watchpointFaultPc))
    else $error("fault address changed unasked");
  chk_catch_load: assert property ( // R7
    cpWrite.writeCatch
    |=> vectorCatchEnables == ($past(cpWrite.data) & `EVC_CATCH_WMASK))
    else $error("catch write not loaded");
  chk_catch_hold: assert property ( // R7
    !cpWrite.writeCatch |=> $stable(vectorCatchEnables))
    else $error("catch enables changed unasked");
  chk_quiet_mode: assert property ( // R2
    debugModeSel != `EVC_DMODE_EXCEPTION &&
    debugModeSel != `EVC_DMODE_HALT |=> !catchException && !catchHalt)
    else $error("event raised in quiet mode");
  chk_no_fetch: assert property ( // R3
    !fetch.valid |=> !catchException && !catchHalt)
    else $error("event without committed fetch");

  cov_exception: cover property (catchException);
  cov_halt: cover property (catchHalt);
  cov_ns_catch: cover property (fetch.valid && hit && !chkSecure);
  cov_wpt: cover property (wpt.valid ##1 !wpt.valid);
  cov_barrier: cover property (cpWrite.writeCatch ##[1:4]
    instructionMemoryBarrier);
endmodule

// file: tb/exception_vector_catch_tb.sv
// Self-checking bench for the vector catch block against a bench model.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  errors++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module exception_vector_catch_tb;
  import evc_pkg::*;
  // ****************
  // Signals
  // ****************
  logic core_clk;
  logic nrst;
  logic instructionMemoryBarrier;
  evc_cpw_t cpWrite;
  evc_ctx_t ctx;
  evc_fetch_t fetch;
  evc_wpt_t wpt;
  logic [1:0] debugModeSel;
  logic [31:0] vectorCatchEnables;
  logic [31:0] watchpointFaultPc;
  logic catchException;
  logic catchHalt;
  int errors;
  int check_count;
  logic [31:0] pend;
  logic [31:0] act;

  evc_vector_catch i_evc_vector_catch (
    .core_clk(core_clk),
    .nrst(nrst),
    .cpWrite(cpWrite),
    .instructionMemoryBarrier(instructionMemoryBarrier),
    .ctx(ctx),
    .fetch(fetch),
    .wpt(wpt),
    .debugModeSel(debugModeSel),
    .vectorCatchEnables(vectorCatchEnables),
    .watchpointFaultPc(watchpointFaultPc),
    .catchException(catchException),
    .catchHalt(catchHalt)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************
  // Model
  // ****************
  // caught address
  function automatic logic [31:0] vaddr(int b, evc_ctx_t c);
    logic [31:0] hb;
    hb = c.highVectorsSelect ? 32'hFFFF_0000 : c.nonsecureVectorBase;
    if (b == 0) return c.highVectorsSelect ? 32'hFFFF_0000 : 32'h0000_0000;
    if (b < 8) begin
      if (b == 6 && c.vectoredIrqEnable) return c.lastSecureIrqAddr;
      hb = c.highVectorsSelect ? 32'hFFFF_0000 : c.secureVectorBase;
      return hb + 32'(b * 4);
    end
    if (b < 16) return c.monitorVectorBase + 32'((b - 8) * 4);
    if (b == 30 && c.vectoredIrqEnable) return c.lastNonsecureIrqAddr;
    return hb + 32'((b - 24) * 4);
  endfunction

  function automatic bit mhit(logic [31:0] en, evc_ctx_t c, logic [31:0] a);
    bit sec;
    bit h;
    sec = !c.nonsecureStateFlag || c.procMode == 5'h16;
    h = 1'b0;
    for (int b = 0; b < 32; b++) begin
      if (en[b] && ((b < 16) == sec) && a == vaddr(b, c)) h = 1'b1;
    end
    return h;
  endfunction

  task automatic fetchChk(input logic [31:0] a);
    bit h;
    h = mhit(act, ctx, a);
    fetch = '{1'b1, a};
    @(negedge core_clk);
    fetch.valid = 1'b0;
    `CHK("catchException", h && debugModeSel == 2'h2, catchException)
    `CHK("catchHalt", h && debugModeSel == 2'h1, catchHalt)
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    $display("MISMATCH watchdog exp done got hang");
    results();
  end

  // ****************
  // Sequence
  // ****************
  initial begin
    logic [31:0] a;
    nrst = 1'b0;
    cpWrite = '0;
    instructionMemoryBarrier = 1'b0;
    ctx = '0;
    fetch = '0;
    wpt = '0;
    debugModeSel = 2'h2;
    errors = 0;
    check_count = 0;
    pend = '0;
    act = '0;
    void'($urandom(32'ha085));
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    `CHK("enables", 32'h0000_0000, vectorCatchEnables)
    `CHK("faultPc", 32'h0000_0000, watchpointFaultPc)
    $display("Reset test done");
    // write alone must not arm the catch
    cpWrite = '{1'b1, 1'b0, 32'hFFFF_FFFF};
    pend = 32'hDE00_DCDF;
    @(negedge core_clk);
    cpWrite = '0;
    `CHK("enables", 32'hDE00_DCDF, vectorCatchEnables)
    fetchChk(32'h0000_0000);
    instructionMemoryBarrier = 1'b1;
    act = pend;
    @(negedge core_clk);
    instructionMemoryBarrier = 1'b0;
    fetchChk(32'h0000_0000);
    `CHK("armed", 1'b1, catchException)
    $display("Barrier test done");
    for (int i = 0; i < 400; i++) begin
      ctx = '{1'($urandom), ($urandom % 2) ? 5'h16 : 5'($urandom),
        1'($urandom), 1'($urandom), $urandom & 32'hFFFF_FFE0,
        $urandom & 32'hFFFF_FFE0, $urandom & 32'hFFFF_FFE0,
        $urandom, $urandom};
      debugModeSel = 2'($urandom);
      cpWrite = '{1'($urandom), 1'b0, $urandom};
      instructionMemoryBarrier = 1'($urandom);
      if (cpWrite.writeCatch) pend = cpWrite.data & 32'hDE00_DCDF;
      if (instructionMemoryBarrier) act = pend;
      @(negedge core_clk);
      cpWrite = '0;
      instructionMemoryBarrier = 1'b0;
      `CHK("enables", pend, vectorCatchEnables)
      a = ($urandom % 4 == 0) ? $urandom : vaddr($urandom % 32, ctx);
      fetchChk(a);
    end
    $display("Random catch test done");
    for (int k = 0; k < 3; k++) begin
      a = $urandom;
      wpt = '{1'b1, a, evc_iset_t'(k)};
      @(negedge core_clk);
      wpt = '0;
      a = a + ((k == 0) ? 32'h0000_0008 : (k == 1) ? 32'h0000_0004 : 32'h0);
      `CHK("faultPc", a, watchpointFaultPc)
    end
    a = $urandom;
    cpWrite = '{1'b0, 1'b1, a};
    @(negedge core_clk);
    cpWrite = '0;
    `CHK("faultPc", a, watchpointFaultPc)
    $display("Fault address test done");
    results();
  end
endmodule
